// File: common/pbvc_map.vh
`ifndef PBVC_MAP_VH
`define PBVC_MAP_VH
// ==========================================
// Register byte offsets
`define PBVC_CTRL_OFF      8'h00
`define PBVC_MEAS_A_OFF    8'h04
`define PBVC_MEAS_B_OFF    8'h08
`define PBVC_MEAS_C_OFF    8'h0c
`define PBVC_MPV_OFF       8'h10
`define PBVC_SET_BOOST_OFF 8'h14
`define PBVC_SET_TIME_OFF  8'h18
`define PBVC_SET_BYP_OFF   8'h1c
`define PBVC_SET_INJ_OFF   8'h20
`define PBVC_SET_INJSH_OFF 8'h24
`define PBVC_STATUS_OFF    8'h28
// ==========================================
// Control register bit positions
`define PBVC_B_BOOST_SEL   0
`define PBVC_B_LOCAL_CTL   1
`define PBVC_B_HEAT_REC    2
`define PBVC_B_GC_BYPASS   3
`define PBVC_B_BYP_FN_EN   4
`define PBVC_B_PARALLEL    5
`define PBVC_B_LP_RUN      6
`define PBVC_B_HP_FAULT    7
`define PBVC_B_OUT_ERR     8
`define PBVC_B_MP_ERR      9
`define PBVC_B_FAST_UNLD   10
`define PBVC_B_CASE_PRES   11
`define PBVC_B_PACK_PRES   12
// ==========================================
// Reset values
`define PBVC_CTRL_RST      32'h00001840
`define PBVC_BOOST_RST     32'h00041d1d
`define PBVC_TIME_RST      32'h012c003c
`define PBVC_BYP_RST       32'h00020404
`define PBVC_INJ_RST       32'h00148c8c
`define PBVC_INJSH_RST     32'h00000404
// ==========================================
// Timing
`define PBVC_CLK_HZ        25000000
`define PBVC_TICK_MS       1000
`define PBVC_MPV_HOLD_S    180
`endif

// File: verilog/pbvc_valve_control.v
// Summary of operation
// - Relay ten shows booster enable state
// - Enable needs select yes, local control no
// - Normal mode: outdoor above switch-on temperature
// - Recovery: gas cooler outlet above threshold
// - Recovery with bypass: recovery outlet compared
// - Midpressure valve opening held three minutes
// - Minimum standstill before enabling again
// - Any lost condition drops enable at the next tick, a lost valve opening one tick later
// - Block on no LP, HP fault, sensor error
// - Switch-off temperature is switch-on minus hysteresis
// - Bypass valve only without booster, function enabled
// - Open bypass on low case or pack superheat
// - Close bypass when both exceed min plus hysteresis
// - Single sensor: use available superheat only
// - Fast unload forces bypass valve off
// - Injection valve is plain on/off output
// - Injection needs bypass function off, booster off or parallel
// - Injection on at head temperature limit
// - Injection off at limit minus hysteresis
// - Injection off on low case/pack superheat
// - Superheat injection back on above min plus hysteresis
//
// Register access over APB and the register offsets were decided locally.
`include "pbvc_map.vh"

module pbvc_valve_control #(
    parameter TICK_CYCLES = (`PBVC_CLK_HZ / 1000) * `PBVC_TICK_MS
) (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Outputs to plant
    output reg         relay10Out,
    output reg         bypassValveOut,
    output reg         injectionValveOut
);

    // ==========================================
    // Register file
    reg [31:0] ctrl_reg;
    reg [31:0] measA_reg;
    reg [31:0] measB_reg;
    reg [31:0] measC_reg;
    reg [31:0] mpv_reg;
    reg [31:0] setBoost_reg;
    reg [31:0] setTime_reg;
    reg [31:0] setByp_reg;
    reg [31:0] setInj_reg;
    reg [31:0] setInjSh_reg;

    // Access edge is the first access cycle; pready blocks a second
    // write while the master still holds the same request
    wire access = psel & penable & ~pready;
    // Read-only status is assembled at the end of the module
    wire [31:0] statusWord;
    reg  mapped;
    reg  [31:0] rdMux;

    always @* begin
        mapped = 1'b1;
        rdMux  = 32'h00000000;
        case (paddr)
            `PBVC_CTRL_OFF:      rdMux = ctrl_reg;
            `PBVC_MEAS_A_OFF:    rdMux = measA_reg;
            `PBVC_MEAS_B_OFF:    rdMux = measB_reg;
            `PBVC_MEAS_C_OFF:    rdMux = measC_reg;
            `PBVC_MPV_OFF:       rdMux = mpv_reg;
            `PBVC_SET_BOOST_OFF: rdMux = setBoost_reg;
            `PBVC_SET_TIME_OFF:  rdMux = setTime_reg;
            `PBVC_SET_BYP_OFF:   rdMux = setByp_reg;
            `PBVC_SET_INJ_OFF:   rdMux = setInj_reg;
            `PBVC_SET_INJSH_OFF: rdMux = setInjSh_reg;
            `PBVC_STATUS_OFF:    rdMux = statusWord;
            default:             mapped = 1'b0;
        endcase
    end

    // One wait state: pready rises the cycle after setup+access
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            prdata       <= 32'h00000000;
            ctrl_reg     <= `PBVC_CTRL_RST;
            measA_reg    <= 32'h00000000;
            measB_reg    <= 32'h00000000;
            measC_reg    <= 32'h00000000;
            mpv_reg      <= 32'h00000000;
            setBoost_reg <= `PBVC_BOOST_RST;
            setTime_reg  <= `PBVC_TIME_RST;
            setByp_reg   <= `PBVC_BYP_RST;
            setInj_reg   <= `PBVC_INJ_RST;
            setInjSh_reg <= `PBVC_INJSH_RST;
        end else begin
            pready  <= access;
            pslverr <= access & ~mapped;
            prdata  <= (access & ~pwrite) ? rdMux : 32'h00000000;
            if (access & pwrite) begin
                case (paddr)
                    `PBVC_CTRL_OFF:      ctrl_reg     <= pwdata;
                    `PBVC_MEAS_A_OFF:    measA_reg    <= pwdata;
                    `PBVC_MEAS_B_OFF:    measB_reg    <= pwdata;
                    `PBVC_MEAS_C_OFF:    measC_reg    <= pwdata;
                    `PBVC_MPV_OFF:       mpv_reg      <= pwdata;
                    `PBVC_SET_BOOST_OFF: setBoost_reg <= pwdata;
                    `PBVC_SET_TIME_OFF:  setTime_reg  <= pwdata;
                    `PBVC_SET_BYP_OFF:   setByp_reg   <= pwdata;
                    `PBVC_SET_INJ_OFF:   setInj_reg   <= pwdata;
                    `PBVC_SET_INJSH_OFF: setInjSh_reg <= pwdata;
                    default:             ;
                endcase
            end
        end
    end

    // ==========================================
    // Field decode
    wire boostSel  = ctrl_reg[`PBVC_B_BOOST_SEL];
    wire localCtl  = ctrl_reg[`PBVC_B_LOCAL_CTL];
    wire heatRec   = ctrl_reg[`PBVC_B_HEAT_REC];
    wire gcBypass  = ctrl_reg[`PBVC_B_GC_BYPASS];
    wire bypFnEn   = ctrl_reg[`PBVC_B_BYP_FN_EN];
    wire parallel  = ctrl_reg[`PBVC_B_PARALLEL];
    wire lpRun     = ctrl_reg[`PBVC_B_LP_RUN];
    wire hpFault   = ctrl_reg[`PBVC_B_HP_FAULT];
    wire outErr    = ctrl_reg[`PBVC_B_OUT_ERR];
    wire mpErr     = ctrl_reg[`PBVC_B_MP_ERR];
    wire fastUnld  = ctrl_reg[`PBVC_B_FAST_UNLD];
    wire casePres  = ctrl_reg[`PBVC_B_CASE_PRES];
    wire packPres  = ctrl_reg[`PBVC_B_PACK_PRES];

    // Measurements are signed whole degrees or kelvin
    wire signed [16:0] outdoorT = {measA_reg[15], measA_reg[15:0]};
    wire signed [16:0] gcOutT   = {measA_reg[31], measA_reg[31:16]};
    wire signed [16:0] hrOutT   = {measB_reg[15], measB_reg[15:0]};
    wire signed [16:0] headT    = {measB_reg[31], measB_reg[31:16]};
    wire signed [16:0] caseSh   = {measC_reg[15], measC_reg[15:0]};
    wire signed [16:0] packSh   = {measC_reg[31], measC_reg[31:16]};
    wire        [7:0]  mpvOpen  = mpv_reg[7:0];

    // Switch-on temperatures may be negative
    wire signed [16:0] onNorm = {{9{setBoost_reg[7]}}, setBoost_reg[7:0]};
    wire signed [16:0] onRec  = {{9{setBoost_reg[15]}},
                                 setBoost_reg[15:8]};
    wire signed [16:0] bHyst  = {9'h000, setBoost_reg[23:16]};
    wire        [7:0]  mpvMin = setTime_reg[7:0];
    wire        [15:0] idleS  = setTime_reg[31:16];
    wire signed [16:0] minCB  = {9'h000, setByp_reg[7:0]};
    wire signed [16:0] minPB  = {9'h000, setByp_reg[15:8]};
    wire signed [16:0] shHyst = {9'h000, setByp_reg[23:16]};
    wire signed [16:0] limN   = {9'h000, setInj_reg[7:0]};
    wire signed [16:0] limR   = {9'h000, setInj_reg[15:8]};
    wire signed [16:0] iHyst  = {9'h000, setInj_reg[23:16]};
    wire signed [16:0] minCI  = {9'h000, setInjSh_reg[7:0]};
    wire signed [16:0] minPI  = {9'h000, setInjSh_reg[15:8]};

    // ==========================================
    // Control tick
    // Last count of one control period; a tick is one clock wide
    localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

    reg  [31:0] tickCnt_reg;
    reg         tick_reg;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tickCnt_reg <= 32'h00000000;
            tick_reg    <= 1'b0;
        end else if (tickCnt_reg >= TICK_LAST) begin
            tickCnt_reg <= 32'h00000000;
            tick_reg    <= 1'b1;
        end else begin
            tickCnt_reg <= tickCnt_reg + 32'h00000001;
            tick_reg    <= 1'b0;
        end
    end

    // ==========================================
    // Booster enable
    // Hold interval in ticks; must fit the counter width
    localparam [7:0] MPV_HOLD = `PBVC_MPV_HOLD_S;

    reg [7:0]  mpvCnt_reg;
    reg [15:0] idleCnt_reg;
    reg [7:0]  mpvCnt_next;
    reg [15:0] idleCnt_next;

    wire signed [16:0] boostT = !heatRec ? outdoorT :
                                gcBypass ? hrOutT : gcOutT;
    wire signed [16:0] boostOn = heatRec ? onRec : onNorm;
    wire tempOk = relay10Out ? (boostT > boostOn - bHyst)
                             : (boostT > boostOn);
    // Opening must hold for the full interval
    wire mpvOk  = (mpvCnt_reg >= MPV_HOLD);
    wire idleOk = (idleCnt_reg >= idleS);
    wire blocked = ~lpRun | hpFault | outErr | mpErr;
    wire modeOk = boostSel & ~localCtl;
    // Any missing term drops the relay at the next tick
    wire condOk  = modeOk & ~blocked;
    wire plantOk = tempOk & mpvOk;
    // Standstill only gates a fresh start, not a running one
    wire startOk = relay10Out | idleOk;
    wire boostNext = condOk & plantOk & startOk;

    always @* begin
        mpvCnt_next  = mpvCnt_reg;
        idleCnt_next = idleCnt_reg;
        if (mpvOpen <= mpvMin) begin
            mpvCnt_next = 8'h00;
        end else if (!mpvOk) begin
            mpvCnt_next = mpvCnt_reg + 8'h01;
        end
        // Saturates so a long idle never wraps to zero
        if (relay10Out) begin
            idleCnt_next = 16'h0000;
        end else if (idleCnt_reg != 16'hffff) begin
            idleCnt_next = idleCnt_reg + 16'h0001;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mpvCnt_reg  <= 8'h00;
            idleCnt_reg <= 16'h0000;
            relay10Out  <= 1'b0;
        end else if (tick_reg) begin
            mpvCnt_reg  <= mpvCnt_next;
            idleCnt_reg <= idleCnt_next;
            relay10Out  <= boostNext;
        end
    end

    // ==========================================
    // Hot gas bypass valve
    // Absent sensor neither opens nor holds
    wire bypLow  = (casePres & (caseSh < minCB)) |
                   (packPres & (packSh < minPB));
    wire bypHigh = (~casePres | (caseSh > minCB + shHyst)) &
                   (~packPres | (packSh > minPB + shHyst)) &
                   (casePres | packPres);
    // Allowed only without booster, no unload
    wire bypAllow = ~relay10Out & bypFnEn & ~fastUnld;

    reg bypassValve_next;

    // Between the two thresholds the valve keeps its state
    always @* begin
        bypassValve_next = bypassValveOut;
        if (!bypAllow || !(casePres || packPres)) begin
            bypassValve_next = 1'b0;
        end else if (bypLow) begin
            bypassValve_next = 1'b1;
        end else if (bypHigh) begin
            bypassValve_next = 1'b0;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bypassValveOut <= 1'b0;
        end else if (tick_reg) begin
            bypassValveOut <= bypassValve_next;
        end
    end

    // ==========================================
    // Suction gas injection valve
    reg headOn_reg;
    reg shBlock_reg;

    wire signed [16:0] headLim = heatRec ? limR : limN;
    wire shLow  = (casePres & (caseSh < minCI)) |
                  (packPres & (packSh < minPI));
    wire shHigh = (~casePres | (caseSh > minCI + shHyst)) &
                  (~packPres | (packSh > minPI + shHyst));
    wire injAvail = ~bypFnEn & (~relay10Out | parallel);

    reg headOn_next;
    reg shBlock_next;

    always @* begin
        headOn_next  = headOn_reg;
        shBlock_next = shBlock_reg;
        // On at limit, off at limit minus hysteresis
        if (headT >= headLim) begin
            headOn_next = 1'b1;
        end else if (headT <= headLim - iHyst) begin
            headOn_next = 1'b0;
        end
        // Low superheat blocks, released above hysteresis
        if (shLow) begin
            shBlock_next = 1'b1;
        end else if (shHigh) begin
            shBlock_next = 1'b0;
        end
    end

    // The valve follows the latches of the previous tick: one tick of
    // extra reaction time, traded for a short output path
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            headOn_reg        <= 1'b0;
            shBlock_reg       <= 1'b0;
            injectionValveOut <= 1'b0;
        end else if (tick_reg) begin
            headOn_reg        <= headOn_next;
            shBlock_reg       <= shBlock_next;
            injectionValveOut <= injAvail & headOn_reg & ~shBlock_reg;
        end
    end

    // ==========================================
    // Status word
    // Latch states are exposed so software can see why a valve is shut
    assign statusWord = {25'h0000000, shBlock_reg, headOn_reg,
                         idleOk, mpvOk, injectionValveOut,
                         bypassValveOut, relay10Out};

endmodule

// File: tb/pbvc_valve_monitor.sv
// ==========================================
// Port checker for the valve control block
module pbvc_valve_monitor #(
    parameter int TICK_CYCLES = 4
) (
    // Clock and reset
    input logic        clk,
    input logic        reset_n,
    // APB
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // Plant
    input logic        relay10Out,
    input logic        bypassValveOut,
    input logic        injectionValveOut
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    // Outputs move on ticks only, so a change is followed by calm
    sequence s_quiet(sig);
        $stable(sig) [*3];
    endsequence
    a_ready_follows: assert property (s_access |=> pready)
        else $error("pready missing after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("pready without access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    a_valves_exclusive: assert property (
        !(bypassValveOut && injectionValveOut))
        else $error("bypass and injection both on");
    a_relay_held: assert property (
        $changed(relay10Out) |=> s_quiet(relay10Out))
        else $error("relay changed between ticks");
    a_bypass_held: assert property (
        $changed(bypassValveOut) |=> s_quiet(bypassValveOut))
        else $error("bypass changed between ticks");
    a_inj_held: assert property (
        $changed(injectionValveOut) |=> s_quiet(injectionValveOut))
        else $error("injection changed between ticks");
endmodule
bind pbvc_valve_control pbvc_valve_monitor #(
    .TICK_CYCLES(TICK_CYCLES)
) u_monitor (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .relay10Out(relay10Out),
    .bypassValveOut(bypassValveOut),
    .injectionValveOut(injectionValveOut)
);

// File: tb/pbvc_pack_partner.sv
// ==========================================
// Separate pack controller: counts enable starts
module pbvc_pack_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Relay input
    input wire logic boostEnable,
    output int       startCount
);
    timeunit 1ns;
    timeprecision 1ps;
    logic relayLast_reg;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            relayLast_reg <= 1'b0;
            startCount <= 0;
        end else begin
            relayLast_reg <= boostEnable;
            if (boostEnable && !relayLast_reg) begin
                startCount <= startCount + 1;
            end
        end
    end
endmodule

// File: tb/pbvc_valve_control_tb_top.sv
`include "pbvc_map.vh"
module pbvc_valve_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 4;
    localparam logic [7:0] CT = `PBVC_CTRL_OFF;
    localparam logic [7:0] MA = `PBVC_MEAS_A_OFF;
    localparam logic [7:0] MB = `PBVC_MEAS_B_OFF;
    localparam logic [7:0] MC = `PBVC_MEAS_C_OFF;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rdData;
    logic        rdErr;
    wire  [31:0] prdata;
    wire  [2:0]  outs;
    wire         pready;
    wire         pslverr;
    int          n_fail = 0;
    int          comparisons = 0;
    int          startCount;
    always #20 clk = ~clk;
    pbvc_valve_control #(.TICK_CYCLES(TICK)) DUT (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .relay10Out(outs[0]),
        .bypassValveOut(outs[1]), .injectionValveOut(outs[2]));
    pbvc_pack_partner u_partner (.clk(clk), .reset_n(reset_n),
        .boostEnable(outs[0]), .startCount(startCount));
    task automatic stop_test;
        $display("Mismatches %0d of %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t word %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t bit %b not %b", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ticks(input int n);
        repeat (n * TICK) @(posedge clk);
    endtask
    // Write, let the tick lag pass, then look at one output
    task automatic st(input logic [7:0] a, input logic [31:0] d,
                      input int k, input logic e);
        apb(1'b1, a, d);
        ticks(3);
        chk_bit(outs[k], e);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        apb(1'b0, CT, 32'h0);
        chk_word(rdData, `PBVC_CTRL_RST);
        apb(1'b0, `PBVC_SET_TIME_OFF, 32'h0);
        chk_word(rdData, `PBVC_TIME_RST);
        apb(1'b1, 8'h2c, 32'h0000ffff);
        chk_bit(rdErr, 1'b1);
        apb(1'b1, `PBVC_SET_TIME_OFF, 32'h000a003c);
        apb(1'b1, MA, 32'h0000001e);
        apb(1'b1, `PBVC_MPV_OFF, 32'h0000003d);
        apb(1'b1, CT, 32'h00001841);
        ticks(170);
        chk_bit(outs[0], 1'b0);
        ticks(15);
        chk_bit(outs[0], 1'b1);
        st(CT, 32'h00001843, 0, 1'b0);
        st(CT, 32'h00001841, 0, 1'b0);
        ticks(8);
        chk_bit(outs[0], 1'b1);
        chk_word(startCount, 32'd2);
        st(MA, 32'h0000001a, 0, 1'b1);
        st(CT, 32'h000018c1, 0, 1'b0);
        st(CT, 32'h00001841, 0, 1'b0);
        ticks(8);
        chk_bit(outs[0], 1'b0);
        st(MA, 32'h001e001a, 0, 1'b0);
        st(CT, 32'h00001845, 0, 1'b1);
        st(MA, 32'h0014001a, 0, 1'b0);
        apb(1'b1, MB, 32'h0000001e);
        ticks(10);
        st(CT, 32'h0000184d, 0, 1'b1);
        st(CT, 32'h00001851, 1, 1'b0);
        chk_bit(outs[0], 1'b1);
        st(CT, 32'h00001850, 1, 1'b1);
        st(MC, 32'h000a0003, 1, 1'b1);
        st(MC, 32'h000a0005, 1, 1'b1);
        st(MC, 32'h000a0007, 1, 1'b0);
        st(MC, 32'h000a0003, 1, 1'b1);
        st(CT, 32'h00001c50, 1, 1'b0);
        st(CT, 32'h00001850, 1, 1'b1);
        st(CT, 32'h00001050, 1, 1'b0);
        st(CT, 32'h00001840, 2, 1'b0);
        st(MC, 32'h000a000a, 2, 1'b0);
        st(MB, 32'h008c0000, 2, 1'b1);
        st(MB, 32'h00790000, 2, 1'b1);
        st(MB, 32'h00780000, 2, 1'b0);
        st(MB, 32'h008c0000, 2, 1'b1);
        st(MC, 32'h000a0003, 2, 1'b0);
        st(MC, 32'h000a0005, 2, 1'b0);
        st(MC, 32'h000a0007, 2, 1'b1);
        st(CT, 32'h00001850, 2, 1'b0);
        stop_test();
    end
endmodule
